// *** var_pkg.sv ***
// shared constants and carrier types for the address relocation unit
package var_pkg;
    localparam int VA_W = 16;
    localparam int PA_W = 22;
    localparam int PAGE_W = 3;
    localparam int BLK_W = 7;
    localparam int OFS_W = 6;
    localparam int BASE_W = 16;
    localparam int NPAGE = 8;
    localparam int NSET = 6;
    localparam int SET_W = 3;
    localparam int APF_LSB = 13;
    localparam int BLK_LSB = 6;
    // physical address of the peripheral page (octal 17760000)
    localparam logic [21:0] IO_PAGE_BASE = 22'h3F_E000;
    // 16-bit map: virtual 160000 and above is the peripheral page
    localparam logic [2:0] IO_APF = 3'h7;
    // 18-bit map: top 4K words of 128K space
    localparam logic [17:0] IO_18_LIMIT = 18'h3_E000;
    localparam logic [21:0] IO_18_OFFSET = 22'h3C_0000;
    localparam logic [1:0] MODE_KERNEL = 2'h0;
    localparam logic [1:0] MODE_SUPER = 2'h1;
    localparam logic [1:0] MODE_USER = 2'h3;
    localparam int PSW_MODE_HI = 15;
    localparam int PSW_MODE_LO = 14;
    localparam int CTRL_EN_BIT = 0;
    typedef enum logic [2:0]
    {
        VAR_MAP16 = 3'b001,
        VAR_MAP18 = 3'b010,
        VAR_MAP22 = 3'b100
    } var_map_t;
    typedef struct packed
    {
        logic valid;
        logic [VA_W-1:0] va;
        logic [1:0] mode;
        logic ispace;
        logic vector;
    } var_req_t;
    typedef struct packed
    {
        logic valid;
        logic [PA_W-1:0] pa;
        logic io_page;
        logic [SET_W-1:0] set;
    } var_rsp_t;
    typedef struct packed
    {
        logic we;
        logic [SET_W-1:0] set;
        logic [PAGE_W-1:0] page;
        logic [BASE_W-1:0] data;
    } var_wr_t;
endpackage

// *** var_relocate.sv ***
// virtual to physical address relocation unit
// Operation
// R1: three mapping widths: 16, 18, 22 bits
// R2: peripheral page is top 4K words always
// R3: 16-bit: low 28K identity, top 4K peripheral
// R4: 18-bit: each mode mapped into 128K words
// R5: 22-bit: full space, peripheral page on top
// R6: relocation forms 22-bit address from base
// R7: pages are 64-byte blocks, 1 to 128
// R8: mode and space choose register group
// R9: each mode has 8 I and 8 D pages
// R10: vector fetches use kernel data registers
// R11: new status mode bits pick next set; code only latches them to o_vector_mode, set follows i_req.mode
// R12: instruction stream references use I space
// R13: config bit disables D space
// R14: 3-bit page field selects base register
// R15: displacement splits into block and offset
// R16: base is 16-bit physical block number
// R17: block plus base gives bits 21:6
// R18: offset appended below physical block
// R19: control bit 0 enables relocation
// R20: base and descriptor share page select
// R21: carry above bit 21 is dropped
// R22: translation completes in one clock
`timescale 1ns/1ps
module var_relocate
#(
    parameter int NUM_SETS = var_pkg::NSET
)
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // processor reference
    input var_pkg::var_req_t i_req,
    input wire logic [15:0] i_new_psw,
    input wire logic i_psw_load,
    // configuration
    input wire logic [15:0] i_translation_control_register,
    input wire logic i_dspace_enable,
    input var_pkg::var_map_t i_map_mode,
    input var_pkg::var_wr_t i_base_wr,
    // physical side
    output var_pkg::var_rsp_t o_rsp,
    output logic [1:0] o_vector_mode,
    output logic [2:0] o_page_select
);
    import var_pkg::*;

    typedef struct packed
    {
        logic [NUM_SETS-1:0][NPAGE-1:0][BASE_W-1:0] base;
        var_rsp_t rsp;
        logic [1:0] vmode;
        logic [PAGE_W-1:0] psel;
    } var_state_t;

    var_state_t state_r;
    var_state_t state_nxt;

    logic [SET_W-1:0] set_sel;
    logic [PAGE_W-1:0] active_page_field;
    logic [BLK_W-1:0] blk;
    logic [OFS_W-1:0] ofs;
    logic [BASE_W-1:0] base_sel;
    logic [BASE_W-1:0] pblk;
    logic [PA_W-1:0] pa;
    logic reloc_en;
    logic use_d;
    logic [1:0] eff_mode;
    logic [1:0] mode_idx;

    // register group index: mode index (kernel 0, super 1, user 2)*2 + space (0=I, 1=D)
    function automatic logic [1:0] var_mode_idx(input logic [1:0] m);
        unique case (m)
            MODE_KERNEL: var_mode_idx = 2'h0;
            MODE_SUPER: var_mode_idx = 2'h1;
            default: var_mode_idx = 2'h2;
        endcase
    endfunction

    always_comb
    begin
        reloc_en = i_translation_control_register[CTRL_EN_BIT]; // R19
        // vectors always through kernel data space
        eff_mode = i_req.vector ? MODE_KERNEL : i_req.mode; // R10
        use_d = i_req.vector | (~i_req.ispace & i_dspace_enable); // R12 R13
        mode_idx = var_mode_idx(eff_mode); // R8 R9
        set_sel = {mode_idx, use_d};
        active_page_field = i_req.va[APF_LSB +: PAGE_W]; // R14 R20
        blk = i_req.va[BLK_LSB +: BLK_W]; // R15
        ofs = i_req.va[OFS_W-1:0]; // R15
        base_sel = state_r.base[set_sel][active_page_field]; // R16
        // 16-bit sum drops the carry, keeping 22-bit wrap
        pblk = BASE_W'(base_sel + BASE_W'(blk)); // R7 R17 R21
        pa = {pblk, ofs}; // R6 R18
        if (!reloc_en)
        begin
            // unrelocated: top 8K bytes of virtual go to peripheral page
            if (active_page_field == IO_APF)
                pa = IO_PAGE_BASE | PA_W'(i_req.va[APF_LSB-1:0]); // R2 R3
            else
                pa = PA_W'(i_req.va); // R3
        end
        else
        begin
            unique case (i_map_mode)
                VAR_MAP16:
                    pa = (active_page_field == IO_APF) ?
                        (IO_PAGE_BASE | PA_W'(i_req.va[APF_LSB-1:0])) :
                        PA_W'(i_req.va); // R1 R3
                VAR_MAP18:
                    if (pa[17:0] >= IO_18_LIMIT)
                        pa = IO_18_OFFSET | PA_W'(pa[17:0]); // R2 R4
                    else
                        pa = PA_W'(pa[17:0]); // R4
                VAR_MAP22:
                    pa = pa; // R5
                default:
                    pa = pa;
            endcase
        end
        state_nxt = state_r;
        if (i_base_wr.we && (int'(i_base_wr.set) < NUM_SETS))
            state_nxt.base[i_base_wr.set][i_base_wr.page] = i_base_wr.data;
        state_nxt.rsp.valid = i_req.valid; // R22
        state_nxt.rsp.pa = pa;
        state_nxt.rsp.io_page = (pa >= IO_PAGE_BASE); // R2
        state_nxt.rsp.set = set_sel;
        state_nxt.psel = active_page_field; // R20
        if (i_psw_load)
            state_nxt.vmode = i_new_psw[PSW_MODE_HI:PSW_MODE_LO]; // R11
    end

    // base registers hold no defined power-up content, reset to zero anyway
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign o_rsp = state_r.rsp;
    assign o_vector_mode = state_r.vmode;
    assign o_page_select = state_r.psel;

    a_valid_latency: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_req.valid |=> o_rsp.valid) // R22
        else $error("response not one cycle after request");
    a_vector_kernel_d: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_req.valid && i_req.vector |=> o_rsp.set == 3'h1) // R10
        else $error("vector not mapped through kernel data set");
    a_off_identity: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_req.valid && !i_translation_control_register[0]
        && i_req.va[15:13] != 3'h7
        |=> o_rsp.pa == 22'($past(i_req.va))) // R3 R19
        else $error("unrelocated address changed");
    a_off_io_page: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_req.valid && !i_translation_control_register[0]
        && i_req.va[15:13] == 3'h7 |=> o_rsp.io_page) // R2
        else $error("top block not steered to peripheral page");
    a_ispace_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_req.valid && i_req.ispace && !i_req.vector |=> !o_rsp.set[0]) // R12
        else $error("instruction reference used data set");
    a_dspace_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_dspace_enable && !i_req.vector |=> !o_rsp.set[0]) // R13
        else $error("data set used while disabled");
    a_offset_kept: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_req.valid |=> o_rsp.pa[5:0] == $past(i_req.va[5:0])) // R18
        else $error("block offset not preserved");
    a_psw_mode: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_psw_load |=> o_vector_mode == $past(i_new_psw[15:14])) // R11
        else $error("new mode not taken from status word");
    a_page_pair: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1 |=> o_page_select == $past(i_req.va[15:13])) // R20
        else $error("page select not from top three bits");

    // full map: block sum lands in bits 21:6, carry above is lost
    a_map22_block: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_req.valid && reloc_en && i_map_mode == VAR_MAP22
        |=> o_rsp.pa[21:6] == BASE_W'($past(base_sel)
        + BASE_W'($past(blk)))) // R17 R21
        else $error("physical block is not base plus block");

    // 18-bit map stays in 128K words or the peripheral page
    a_map18_range: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_req.valid && reloc_en && i_map_mode == VAR_MAP18
        |=> o_rsp.pa[21:18] == 4'h0 || o_rsp.pa[21:18] == 4'hF) // R4
        else $error("18-bit address outside its space");

    a_map18_io: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_req.valid && reloc_en && i_map_mode == VAR_MAP18
        && pa[17:0] >= IO_18_LIMIT |=> o_rsp.io_page) // R2 R4
        else $error("18-bit top block not on peripheral page");

    a_map16_io: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_req.valid && reloc_en && i_map_mode == VAR_MAP16
        && active_page_field == IO_APF |=> o_rsp.io_page) // R3
        else $error("16-bit top block not on peripheral page");

    a_map16_identity: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_req.valid && reloc_en && i_map_mode == VAR_MAP16
        && active_page_field != IO_APF
        |=> o_rsp.pa == PA_W'($past(i_req.va))) // R1 R3
        else $error("16-bit map changed a low address");

    // peripheral flag must agree with the top nine address bits
    a_io_flag: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        o_rsp.io_page == (&o_rsp.pa[21:13])) // R2
        else $error("peripheral flag disagrees with address");

    a_kernel_set: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_req.valid && !i_req.vector && i_req.mode == MODE_KERNEL
        |=> o_rsp.set[2:1] == 2'h0) // R8
        else $error("kernel reference used wrong group");

    a_super_set: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_req.valid && !i_req.vector && i_req.mode == MODE_SUPER
        |=> o_rsp.set[2:1] == 2'h1) // R8
        else $error("supervisor reference used wrong group");

    a_user_set: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_req.valid && !i_req.vector && i_req.mode == MODE_USER
        |=> o_rsp.set[2:1] == 2'h2) // R8 R9
        else $error("user reference used wrong group");

    // only six groups exist, a seventh code would read nothing
    a_set_legal: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        o_rsp.set < 3'h6) // R9
        else $error("register group out of range");

    a_dspace_on: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_req.valid && !i_req.ispace && i_dspace_enable
        |=> o_rsp.set[0]) // R12 R13
        else $error("data reference missed data group");

    a_base_write: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        i_base_wr.we && (int'(i_base_wr.set) < NUM_SETS)
        |=> state_r.base[$past(i_base_wr.set)][$past(i_base_wr.page)]
        == $past(i_base_wr.data)) // R16
        else $error("base register write lost");

    a_mode_hold: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        !i_psw_load |=> $stable(o_vector_mode)) // R11
        else $error("next mode changed without a load");

    a_idle_quiet: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        !i_req.valid |=> !o_rsp.valid) // R22
        else $error("response without a request");

    c_map22: cover property (@(posedge i_core_clk)
        i_req.valid && i_map_mode == VAR_MAP22
        && i_translation_control_register[0]);
    c_map18_io: cover property (@(posedge i_core_clk)
        i_map_mode == VAR_MAP18 ##1 o_rsp.io_page);
    c_vector: cover property (@(posedge i_core_clk)
        i_req.valid && i_req.vector);
    c_map16_io: cover property (@(posedge i_core_clk)
        i_req.valid && i_map_mode == VAR_MAP16 && active_page_field == IO_APF);
    c_dspace_off: cover property (@(posedge i_core_clk)
        i_req.valid && !i_dspace_enable && !i_req.ispace);
endmodule

// *** var_core_model.sv ***
// processor core model issuing virtual references
`timescale 1ns/1ps
module var_core_model
(
    // clock
    input wire logic i_core_clk,
    // reference wanted by the bench
    input var_pkg::var_req_t i_cmd,
    // reference to the unit
    output var_pkg::var_req_t o_req
);
    import var_pkg::*;
    initial o_req = '0;
    // space flag follows the reference kind given by the bench
    always @(negedge i_core_clk)
    begin
        o_req <= i_cmd;
        // idle address toggles so a stale value never passes
        if (!i_cmd.valid)
            o_req.va <= ~o_req.va;
    end
endmodule

// *** test_var_relocate.sv ***
// self-checking bench for the address relocation unit
`timescale 1ns/1ps
module test_var_relocate;
    import var_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    var_req_t cmd = '0;
    var_req_t req;
    logic [15:0] processor_status_word = '0;
    logic ld = 1'b0;
    logic [15:0] ctl = '0;
    logic dsp = 1'b1;
    var_map_t map = VAR_MAP22;
    var_wr_t wr = '0;
    var_rsp_t rsp;
    logic [1:0] vmode;
    logic [2:0] psel;
    int mismatches = 0;
    int checks_done = 0;
    var_core_model u_var_core_model (.i_core_clk(clk), .i_cmd(cmd),
        .o_req(req));
    var_relocate u_var_relocate (.i_core_clk(clk), .i_rst(rst), .i_req(req),
        .i_new_psw(processor_status_word), .i_psw_load(ld),
        .i_translation_control_register(ctl), .i_dspace_enable(dsp),
        .i_map_mode(map), .i_base_wr(wr), .o_rsp(rsp),
        .o_vector_mode(vmode), .o_page_select(psel));
    initial forever #25 clk = ~clk;
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wbase(input logic [2:0] s, p, input logic [15:0] d);
        @(negedge clk);
        wr <= '{we: 1'b1, set: s, page: p, data: d};
        @(negedge clk);
        wr <= '0;
    endtask
    // set 7 means the group is not compared
    task automatic xlat(input logic [15:0] va, input logic [1:0] m,
        input logic is, vc, input logic [21:0] pa, input logic [2:0] st);
        @(negedge clk);
        cmd <= '{valid: 1'b1, va: va, mode: m, ispace: is, vector: vc};
        @(negedge clk);
        cmd.valid <= 1'b0;
        @(negedge clk);
        check(rsp.valid, 1);
        check(rsp.pa, pa);
        check(rsp.io_page, pa >= 22'h3F_E000);
        check(psel, va[15:13]);
        if (st != 3'h7)
            check(rsp.set, st);
    endtask
    task automatic t_off;
        ctl <= 16'h0000;
        xlat(16'h1234, MODE_USER, 0, 0, 22'h00_1234, 3'h7);
        xlat(16'hE010, MODE_USER, 0, 0, 22'h3F_E010, 3'h7);
    endtask
    task automatic t_map16;
        ctl <= 16'h0001;
        map <= VAR_MAP16;
        xlat(16'h7FFF, MODE_KERNEL, 1, 0, 22'h00_7FFF, 3'h7);
        xlat(16'hE000, MODE_KERNEL, 1, 0, 22'h3F_E000, 3'h7);
        map <= VAR_MAP22;
    endtask
    task automatic t_vector;
        wbase(3'h1, 3'h0, 16'h0003);
        xlat(16'h0045, MODE_USER, 1, 1, 22'h00_0105, 3'h1);
        processor_status_word <= 16'hC000;
        ld <= 1'b1;
        @(negedge clk);
        ld <= 1'b0;
        processor_status_word <= 16'h0000;
        @(negedge clk);
        check(vmode, 2'h3);
    endtask
    task automatic t_sets;
        logic [1:0] md [3];
        int k;
        md = '{MODE_KERNEL, MODE_SUPER, MODE_USER};
        for (k = 0; k < 6; k++)
            wbase(3'(k), 3'h2, 16'(k * 256 + 1));
        for (k = 0; k < 6; k++)
            xlat(16'h4047, md[k / 2], !(k % 2), 0,
                {16'(k * 256 + 2), 6'h07}, 3'(k));
        dsp <= 1'b0;
        xlat(16'h4047, MODE_USER, 0, 0, {16'h0402, 6'h07}, 3'h4);
        dsp <= 1'b1;
    endtask
    task automatic t_wrap;
        wbase(3'h0, 3'h7, 16'hFFFF);
        xlat(16'hFFC5, MODE_KERNEL, 1, 0, 22'h00_1F85, 3'h0);
    endtask
    task automatic t_map18;
        map <= VAR_MAP18;
        wbase(3'h0, 3'h0, 16'h0F80);
        wbase(3'h0, 3'h1, 16'h1001);
        xlat(16'h0000, MODE_KERNEL, 1, 0, 22'h3F_E000, 3'h0);
        xlat(16'h2000, MODE_KERNEL, 1, 0, 22'h00_0040, 3'h0);
        map <= VAR_MAP22;
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        check(rsp, 0);
        rst <= 1'b0;
        t_off();
        t_map16();
        t_vector();
        t_sets();
        t_wrap();
        t_map18();
        final_report();
    end
    // whole run needs about 90 cycles
    initial
    begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule
